// [rtl/ppn_pkg.sv]
// Package for the pushbutton one-shot and mode panel.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz system clock.
package ppn_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Channel count and one-shot timing.
    localparam int PPN_NUM_CHAN = 10;
    localparam int PPN_CLK_HZ = 25000000;
    localparam int PPN_PULSE_MS = 17;
    // Pulse width in cycles: 17 ms at 25 MHz gives 425000 cycles.
    localparam int PPN_PULSE_CYC = (PPN_PULSE_MS * (PPN_CLK_HZ / 1000));
    localparam int PPN_CNT_W = 20;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [3:0] PPN_OFF_CMD = 4'h0;
    localparam logic [3:0] PPN_OFF_DATA = 4'h4;
    localparam logic [3:0] PPN_OFF_STATUS = 4'h8;
    localparam logic [3:0] PPN_OFF_PULSE = 4'hC;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int PPN_CMD_LSB = 0;
    localparam int PPN_CMD_W = 3;
    localparam int PPN_DATA_LETTER_BIT = 10;
    localparam int PPN_STAT_REMOTE_BIT = 16;
    localparam int PPN_STAT_LOCKOUT_BIT = 17;
    localparam int PPN_STAT_LISTEN_BIT = 18;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus command codes written to the command register.
    localparam logic [2:0] PPN_CMD_REMOTE = 3'h1;
    localparam logic [2:0] PPN_CMD_LISTEN = 3'h2;
    localparam logic [2:0] PPN_CMD_LOCKOUT = 3'h3;
    localparam logic [2:0] PPN_CMD_GTL = 3'h4;
    localparam logic [2:0] PPN_CMD_CLR_LOCKOUT = 3'h5;
    localparam logic [2:0] PPN_CMD_PANEL_RESET = 3'h6;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [9:0] PPN_RST_CHAN = 10'h3FF;
    localparam logic PPN_RST_REMOTE = 1'b0;
    localparam logic PPN_RST_LOCKOUT = 1'b0;
    localparam logic PPN_RST_LISTEN = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI response codes.
    localparam logic [1:0] PPN_RESP_OKAY = 2'h0;
    localparam logic [1:0] PPN_RESP_SLVERR = 2'h2;

endpackage

// [rtl/ppn_panel.sv]
// Front-panel one-shots, output-state latches, mode logic and AXI4-Lite slave.
// Assumes synchronous channel button inputs that idle high, a local button that idles low, and a synchronous reset.
//
// Function
// - Ten independent non-retriggerable button pulse generators.
// - Falling button input starts 17 ms pulse.
// - Local mode: pulse clocks matching state flip-flop.
// - Channel LED lit while channel is on.
// - A local press that starts a pulse inverts its channel state.
// - Exactly one mode LED lit, local or remote.
// - Panel reset forces local unless lockout active.
// - Addressing command in remote sets listen flag.
// - Go-to-local command clears the listen flag.
// - Power-up: local mode, all channels on.
// - On-letter data message sets listed channels on.
// - Off-letter data message sets listed channels off.
// - Local mode: state toggles per button pulse.
// - Lockout ignores local button; otherwise selects local.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps

module ppn_panel
    import ppn_pkg::*;
#(
    parameter int PULSE_CYC = PPN_PULSE_CYC
)
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [9:0] btn_n_i,
    input wire logic local_btn_i,
    output logic [9:0] chan_led_o,
    output logic [9:0] oneshot_o,
    output logic led_local_o,
    output logic led_remote_o,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.
    localparam logic [PPN_CNT_W-1:0] PULSE_LAST = PPN_CNT_W'(PULSE_CYC - 1);

    logic [9:0] btn_prev;
    logic [9:0] pulse_start;
    logic [9:0] pulse_active;
    logic [9:0] chan_state;
    logic [9:0] next_chan_state;
    logic remote;
    logic next_remote;
    logic lockout;
    logic next_lockout;
    logic listen;
    logic next_listen;

    logic aw_full;
    logic [3:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic rd_fire;
    logic wr_is_cmd;
    logic wr_is_data;
    logic wr_is_ro;
    logic [3:0] ar_off;
    logic rd_hit;
    logic [31:0] rd_word;
    logic [2:0] cmd_code;
    logic cmd_valid;
    logic data_valid;
    logic data_letter_on;
    logic [9:0] data_mask;

    logic cmd_remote;
    logic cmd_listen;
    logic cmd_lockout;
    logic cmd_gtl;
    logic cmd_clr_lockout;
    logic cmd_panel_reset;
    logic local_mode;
    logic local_btn_take;
    logic [9:0] toggle_mask;
    logic [9:0] msg_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // One-shot per button: a falling input starts a pulse only when idle.
    // A press during a pulse is dropped, so the pulse never stretches.
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            btn_prev <= 10'h3FF;
        end
        else
        begin
            btn_prev <= btn_n_i;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PPN_NUM_CHAN; gi = gi + 1)
        begin : g_shot
            logic [PPN_CNT_W-1:0] cnt;
            logic busy;

            // Start on a high-to-low edge of the button while no pulse runs.
            assign pulse_start[gi] = btn_prev[gi] & ~btn_n_i[gi] & ~busy;
            assign pulse_active[gi] = busy;

            // Count the pulse width up to the derived terminal count.
            always_ff @(posedge clk_sys_i)
            begin
                if (srst_i)
                begin
                    busy <= 1'b0;
                    cnt <= '0;
                end
                else if (pulse_start[gi])
                begin
                    busy <= 1'b1;
                    cnt <= '0;
                end
                else if (busy)
                begin
                    cnt <= cnt + PPN_CNT_W'(1);
                    busy <= (cnt != PULSE_LAST);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data are latched in either order.
    assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full & ~s_axi_bvalid;
    assign wr_fire = aw_full & w_full & ~s_axi_bvalid;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            aw_full <= 1'b0;
            aw_addr <= 4'h0;
        end
        else if (s_axi_awvalid & s_axi_awready)
        begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr[3:0];
        end
        else if (wr_fire)
        begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            w_full <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid & s_axi_wready)
        begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (wr_fire)
        begin
            w_full <= 1'b0;
        end
    end

    // Write decode: command and data registers act, read-only ones ignore.
    assign wr_is_cmd = (aw_addr == PPN_OFF_CMD);
    assign wr_is_data = (aw_addr == PPN_OFF_DATA);
    assign wr_is_ro = (aw_addr == PPN_OFF_STATUS) | (aw_addr == PPN_OFF_PULSE);
    assign cmd_valid = wr_fire & wr_is_cmd & w_strb[0];
    assign cmd_code = w_data[PPN_CMD_LSB +: PPN_CMD_W];
    assign data_valid = wr_fire & wr_is_data & (w_strb[1:0] == 2'h3);
    assign data_letter_on = w_data[PPN_DATA_LETTER_BIT];
    assign data_mask = w_data[PPN_NUM_CHAN-1:0];

    // Write response goes out the cycle after both halves are present.
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PPN_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_is_cmd | wr_is_data | wr_is_ro) ? PPN_RESP_OKAY : PPN_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side: one read in flight, answered the next cycle.
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign ar_off = s_axi_araddr[3:0];
    assign rd_hit = (ar_off == PPN_OFF_CMD) | (ar_off == PPN_OFF_DATA)
                  | (ar_off == PPN_OFF_STATUS) | (ar_off == PPN_OFF_PULSE);

    // Read mux: status shows the live latches and mode flags.
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (ar_off == PPN_OFF_STATUS)
        begin
            rd_word[PPN_NUM_CHAN-1:0] = chan_state;
            rd_word[PPN_STAT_REMOTE_BIT] = remote;
            rd_word[PPN_STAT_LOCKOUT_BIT] = lockout;
            rd_word[PPN_STAT_LISTEN_BIT] = listen;
        end
        else if (ar_off == PPN_OFF_PULSE)
        begin
            rd_word[PPN_NUM_CHAN-1:0] = pulse_active;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= PPN_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? PPN_RESP_OKAY : PPN_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode.
    assign cmd_remote = cmd_valid & (cmd_code == PPN_CMD_REMOTE);
    assign cmd_listen = cmd_valid & (cmd_code == PPN_CMD_LISTEN);
    assign cmd_lockout = cmd_valid & (cmd_code == PPN_CMD_LOCKOUT);
    assign cmd_gtl = cmd_valid & (cmd_code == PPN_CMD_GTL);
    assign cmd_clr_lockout = cmd_valid & (cmd_code == PPN_CMD_CLR_LOCKOUT);
    assign cmd_panel_reset = cmd_valid & (cmd_code == PPN_CMD_PANEL_RESET);

    ////////////////////////////////////////////////////////////////////////////////
    // Mode flags: remote, lockout and listen.
    assign local_mode = ~remote;
    assign local_btn_take = local_btn_i & ~lockout;

    always_comb
    begin
        next_remote = remote;
        if (cmd_remote)
        begin
            next_remote = 1'b1;
        end
        else if (cmd_gtl | local_btn_take)
        begin
            next_remote = 1'b0;
        end
        else if (cmd_panel_reset & ~lockout)
        begin
            next_remote = 1'b0;
        end
    end

    // Lockout is set and cleared only by bus commands.
    assign next_lockout = cmd_lockout | (lockout & ~cmd_clr_lockout);

    // Listen needs remote mode; go-to-local always clears it.
    always_comb
    begin
        next_listen = listen;
        if (cmd_gtl)
        begin
            next_listen = 1'b0;
        end
        else if (cmd_listen & remote)
        begin
            next_listen = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            remote <= PPN_RST_REMOTE;
            lockout <= PPN_RST_LOCKOUT;
            listen <= PPN_RST_LISTEN;
        end
        else
        begin
            remote <= next_remote;
            lockout <= next_lockout;
            listen <= next_listen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output-state latches: local pulses toggle, data messages set or clear.
    assign toggle_mask = local_mode ? pulse_start : 10'h000;
    assign msg_mask = (data_valid & remote & listen) ? data_mask : 10'h000;

    always_comb
    begin
        next_chan_state = chan_state ^ toggle_mask;
        if (data_letter_on)
        begin
            next_chan_state = next_chan_state | msg_mask;
        end
        else
        begin
            next_chan_state = next_chan_state & ~msg_mask;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            chan_state <= PPN_RST_CHAN;
        end
        else
        begin
            chan_state <= next_chan_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Indicator outputs, straight from flip-flops; led_local_o inverts remote.
    assign chan_led_o = chan_state;
    assign oneshot_o = pulse_active;
    assign led_local_o = ~remote;
    assign led_remote_o = remote;

endmodule

// [sim/ppn_panel_asserts.sv]
// Checker for the panel block, watching only the top ports.
// Assumes PULSE_CYC equals the value of the bound design instance.
`timescale 1ns/10ps
module ppn_panel_asserts #(
    parameter int PULSE_CYC = 8
)
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [9:0] btn_n_i,
    input wire logic [9:0] chan_led_o,
    input wire logic [9:0] oneshot_o,
    input wire logic led_local_o,
    input wire logic led_remote_o,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    int wid;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////
    // Counts the high cycles of the channel 0 pulse.
    always_ff @(posedge clk_sys_i)
    begin
        wid <= oneshot_o[0] ? wid + 1 : 0;
    end
    // A fresh press seen while the one-shot is idle.
    sequence press0;
        $fell(btn_n_i[0]) && !oneshot_o[0];
    endsequence
    // A pulse starting on channel 0.
    sequence start0;
        $rose(oneshot_o[0]);
    endsequence
    ////////////////////////////////////////
    mode_exclusive_a: assert property (led_local_o != led_remote_o)
        else $error("mode lamps not exclusive");
    reset_state_a: assert property ($past(srst_i) |->
        chan_led_o == 10'h3FF && led_local_o && oneshot_o == 10'h000)
        else $error("state after reset wrong");
    pulse_start_a: assert property (press0 |=> oneshot_o[0])
        else $error("press did not start pulse");
    pulse_width_a: assert property ($fell(oneshot_o[0]) |-> wid == PULSE_CYC)
        else $error("pulse width wrong");
    no_extend_a: assert property (wid <= PULSE_CYC)
        else $error("pulse extended");
    local_toggle_a: assert property (start0 and $past(led_local_o) |->
        chan_led_o[0] != $past(chan_led_o[0]))
        else $error("local press did not toggle");
    remote_hold_a: assert property (start0 and $past(led_remote_o) &&
        !$rose(s_axi_bvalid) |-> $stable(chan_led_o[0]))
        else $error("remote press toggled");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule

bind ppn_panel ppn_panel_asserts #(.PULSE_CYC(PULSE_CYC)) u_chk (.clk_sys_i, .srst_i,
    .btn_n_i, .chan_led_o, .oneshot_o, .led_local_o, .led_remote_o, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// [sim/ppn_panel_model.sv]
// Front-panel model: channel buttons and the local button.
// Assumes the bench asks for presses as levels on the system clock.
`timescale 1ns/10ps
module ppn_panel_model
(
    input wire logic clk_sys_i,
    input wire logic [9:0] press_i,
    input wire logic loc_i,
    output logic [9:0] btn_n_o,
    output logic local_btn_o
);
    ////////////////////////////////////////
    // Channel buttons rest high and pull low while held; the local button rests low.
    initial
    begin
        btn_n_o = 10'h3FF;
        local_btn_o = 1'b0;
    end
    // Contacts follow the request one cycle later.
    always @(posedge clk_sys_i)
    begin
        btn_n_o <= ~press_i;
        local_btn_o <= loc_i;
    end
endmodule

// [sim/test_ppn_panel.sv]
// Self-checking bench for the panel block.
// Assumes a short one-shot of 8 cycles and AXI4-Lite register access.
`timescale 1ns/10ps
module test_ppn_panel import ppn_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [9:0] push = 10'h000;
    logic loc = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [31:0] araddr = 32'h0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] rd;
    logic awready, wready, bvalid, arready, rvalid, led_local, led_remote, local_btn;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata;
    logic [9:0] chan_led, oneshot, btn_n;
    int bad_count = 0;
    int checked = 0;
    ////////////////////////////////////////
    ppn_panel #(.PULSE_CYC(8)) i_dut (.clk_sys_i, .srst_i, .btn_n_i(btn_n),
        .local_btn_i(local_btn), .chan_led_o(chan_led), .oneshot_o(oneshot),
        .led_local_o(led_local), .led_remote_o(led_remote), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ppn_panel_model u_model (.clk_sys_i, .press_i(push), .loc_i(loc),
        .btn_n_o(btn_n), .local_btn_o(local_btn));
    // Clock of 40 ns period.
    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    ////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Offers address and data together and waits for the response.
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge clk_sys_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Waits for the response as long as it takes; the watchdog ends a hang.
        do
        begin
            @(negedge clk_sys_i);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            resp = bresp;
            @(posedge clk_sys_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
    endtask
    task rd_reg(input logic [31:0] a, output logic [31:0] d);
        logic ta, got;
        @(posedge clk_sys_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge clk_sys_i);
            ta = arvalid && arready;
            got = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge clk_sys_i);
            if (ta) arvalid <= 1'b0;
        end while (!got);
        rready <= 1'b0;
    endtask
    task cmd(input logic [2:0] c);
        wr(32'h0, {29'h0, c});
    endtask
    // Status holds channels, then remote, lockout and listen at bit 16.
    task stat(input logic [9:0] ch, input logic [2:0] f);
        rd_reg(32'h8, rd);
        chk(rd, {13'h0, f, 6'h0, ch});
        chk({30'h0, resp}, {30'h0, PPN_RESP_OKAY});
    endtask
    // Holds buttons for three cycles, then lets go.
    task hit(input logic [9:0] m, input logic l);
        @(posedge clk_sys_i);
        push <= m;
        loc <= l;
        repeat (3) @(posedge clk_sys_i);
        push <= 10'h000;
        loc <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    // Test sequence.
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(negedge clk_sys_i);
        chk({21'h0, led_local, chan_led}, 32'h7FF);
        stat(10'h3FF, 3'h0);
        $display("test power-up done");
        hit(10'h008, 1'b0);
        chk({22'h0, oneshot}, 32'h008);
        chk({22'h0, chan_led}, 32'h3F7);
        hit(10'h008, 1'b0);
        chk({22'h0, oneshot ^ chan_led}, 32'h3FF);
        repeat (4) @(negedge clk_sys_i);
        chk({22'h0, oneshot}, 32'h000);
        hit(10'h008, 1'b0);
        stat(10'h3FF, 3'h0);
        $display("test local toggle done");
        cmd(PPN_CMD_REMOTE);
        chk({30'h0, led_remote, led_local}, 32'h2);
        chk({30'h0, resp}, {30'h0, PPN_RESP_OKAY});
        hit(10'h001, 1'b0);
        stat(10'h3FF, 3'h1);
        wr(32'h4, 32'h000002AA);
        stat(10'h3FF, 3'h1);
        cmd(PPN_CMD_LISTEN);
        wr(32'h4, 32'h000002AA);
        stat(10'h155, 3'h5);
        wr(32'h4, 32'h0000040A);
        stat(10'h15F, 3'h5);
        chk({31'h0, led_remote}, 32'h1);
        $display("test remote data done");
        cmd(PPN_CMD_LOCKOUT);
        hit(10'h000, 1'b1);
        stat(10'h15F, 3'h7);
        cmd(PPN_CMD_PANEL_RESET);
        stat(10'h15F, 3'h7);
        cmd(PPN_CMD_GTL);
        stat(10'h15F, 3'h2);
        cmd(PPN_CMD_CLR_LOCKOUT);
        cmd(PPN_CMD_REMOTE);
        hit(10'h000, 1'b1);
        stat(10'h15F, 3'h0);
        cmd(PPN_CMD_REMOTE);
        cmd(PPN_CMD_PANEL_RESET);
        stat(10'h15F, 3'h0);
        hit(10'h001, 1'b0);
        stat(10'h15E, 3'h0);
        rd_reg(32'h2, rd);
        chk(rd, 32'h0);
        chk({30'h0, resp}, {30'h0, PPN_RESP_SLVERR});
        wr(32'h2, 32'h0000_0000);
        chk({30'h0, resp}, {30'h0, PPN_RESP_SLVERR});
        $display("test mode control done");
        end_sim;
    end
    // Watchdog against a hung handshake.
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        end_sim;
    end
endmodule
